/* common/pinmux_cfg.svh */
`ifndef PINMUX_CFG_SVH
`define PINMUX_CFG_SVH

// register numbers of the two pin control registers
`define MIC_REG_ADDR   8'h34
`define OUT_REG_ADDR   8'h35
`define REG_AW         8
`define REG_DW         8
`define RD_ZERO        8'h00

// mic data pin control field layout
`define MIC_FUNC_MSB   5
`define MIC_FUNC_LSB   2
`define MIC_BUF_BIT    1
`define GPO_BIT        0

// serial out pin control field layout
`define KEEP_BIT       4
`define OUT_FUNC_MSB   3
`define OUT_FUNC_LSB   1

// reset values
`define MIC_FUNC_RST   4'h0
`define OUT_FUNC_RST   3'h1
`define KEEP_DIS_RST   1'b1
`define GPO_RST        1'b0

// mic data pin function codes
`define MIC_F_OFF      4'h0
`define MIC_F_IN       4'h1
`define MIC_F_GPI      4'h2
`define MIC_F_GPO      4'h3
`define MIC_F_DIVCLK   4'h4
`define MIC_F_INTA     4'h5
`define MIC_F_INTB     4'h6
`define MIC_F_SBCLK    4'h8
`define MIC_F_SWCLK    4'h9
`define MIC_F_MODCLK   4'hA

// serial out pin function codes
`define OUT_F_OFF      3'h0
`define OUT_F_SDATA    3'h1
`define OUT_F_GPO      3'h2
`define OUT_F_DIVCLK   3'h3
`define OUT_F_INTA     3'h4
`define OUT_F_INTB     3'h5
`define OUT_F_SBCLK    3'h6
`define OUT_F_SWCLK    3'h7

// interrupt pulse timing
`define CLK_PERIOD_NS  25
`define INT_PULSE_NS   2000000
`define INT_PERIOD_NS  4000000
`define PULSE_CNT_W    18
`define INT_PULSE_CYC  ((`INT_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INT_PERIOD_CYC ((`INT_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

/* common/pinmux_pkg.sv */
package pinmux_pkg;
  // function field types
  typedef logic [3:0] mic_func_t;
  typedef logic [2:0] out_func_t;
  // interrupt pulse shaper states
  typedef enum logic [1:0] {
    PULSE_IDLE,
    PULSE_HIGH,
    PULSE_LOW
  } pulse_state_e;
endpackage : pinmux_pkg

/* core/int_pulse_shaper.sv */
`timescale 1ns/1ps
`include "pinmux_cfg.svh"

module int_pulse_shaper #(
  parameter logic [`PULSE_CNT_W-1:0] PULSE_CYC  = `PULSE_CNT_W'(`INT_PULSE_CYC),
  parameter logic [`PULSE_CNT_W-1:0] PERIOD_CYC = `PULSE_CNT_W'(`INT_PERIOD_CYC)
) (
  // clock and reset
  input  wire logic clk_i,
  input  wire logic rst_b_i,
  // event and mode
  input  wire logic event_i,
  input  wire logic repeat_i,
  input  wire logic flag_read_i,
  // shaped line
  output logic      pulse_o
);

  pinmux_pkg::pulse_state_e state_reg;  // current phase
  pinmux_pkg::pulse_state_e state_next;
  logic [`PULSE_CNT_W-1:0]  cnt_reg;    // cycles into phase
  logic [`PULSE_CNT_W-1:0]  cnt_next;
  logic                     rep_reg;    // train still running

  // phase sequencing; a new event restarts even during a flag read
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + `PULSE_CNT_W'(1);
    if (event_i) begin
      state_next = pinmux_pkg::PULSE_HIGH; // R17
      cnt_next   = '0;
    end else begin
      case (state_reg)
        pinmux_pkg::PULSE_HIGH: begin
          // the pulse is never cut short, only the train
          if (cnt_reg == PULSE_CYC - `PULSE_CNT_W'(1)) begin
            cnt_next   = '0;
            state_next = (rep_reg && !flag_read_i) ? pinmux_pkg::PULSE_LOW
                                                    : pinmux_pkg::PULSE_IDLE; // R17
          end
        end
        pinmux_pkg::PULSE_LOW: begin
          if (flag_read_i) begin
            state_next = pinmux_pkg::PULSE_IDLE; // R17
            cnt_next   = '0;
          end else if (cnt_reg == PERIOD_CYC - PULSE_CYC - `PULSE_CNT_W'(1)) begin
            state_next = pinmux_pkg::PULSE_HIGH;
            cnt_next   = '0;
          end
        end
        default: begin
          state_next = pinmux_pkg::PULSE_IDLE;
          cnt_next   = '0;
        end
      endcase
    end
  end

  // phase and counter
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_reg <= pinmux_pkg::PULSE_IDLE;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  // repeat mode latched at the event; set wins over the flag read
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rep_reg <= 1'b0;
    end else if (event_i) begin
      rep_reg <= repeat_i;
    end else if (flag_read_i) begin
      rep_reg <= 1'b0;
    end
  end

  // active-high line straight from a flop
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      pulse_o <= 1'b0;
    end else begin
      pulse_o <= (state_next == pinmux_pkg::PULSE_HIGH); // R17
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);

  pulse_start_a: assert property ( // R17
    event_i |=> pulse_o
  ) else $error("pulse did not start after event");

  pulse_end_a: assert property ( // R17
    (state_reg == pinmux_pkg::PULSE_HIGH) && (cnt_reg == PULSE_CYC - `PULSE_CNT_W'(1))
    && !event_i |=> !pulse_o
  ) else $error("pulse longer than its width");

  pulse_len_a: assert property ( // R17
    (state_reg == pinmux_pkg::PULSE_HIGH) |-> (cnt_reg < PULSE_CYC) && pulse_o
  ) else $error("pulse counter beyond width");

  pulse_train_c: cover property (
    (state_reg == pinmux_pkg::PULSE_LOW) ##1 (state_reg == pinmux_pkg::PULSE_HIGH)
  );

endmodule : int_pulse_shaper

/* core/multifunction_pin_select.sv */
`timescale 1ns/1ps
`include "pinmux_cfg.svh"

// Behaviour
// (R1) mic pin code zero: both buffers off
// (R2) code one: input feeding secondary clocks, mic
// (R3) code two: general input, readable level
// (R4) code three: drive stored bit zero
// (R5) code four: drive divided clock output
// (R6) codes five, six: interrupt line a, b
// (R7) codes eight, nine: secondary bit, word clock
// (R8) code ten: drive modulator clock
// (R9) software avoids reserved mic pin codes
// (R10) bit one reads input buffer value
// (R11) out pin bit four: keeper disable, resets one
// (R12) out pin code resets one; zero powers off
// (R13) out code two drives stored bit zero
// (R14) out codes three-five: clock, interrupts
// (R15) out codes six, seven: secondary clocks
// (R16) software writes reserved bits as reset
// (R17) interrupt lines: 2 ms high pulses
// (R18) driver enabled only for output codes
module multifunction_pin_select #(
  parameter logic [`PULSE_CNT_W-1:0] INT_PULSE_CYC  = `PULSE_CNT_W'(`INT_PULSE_CYC),
  parameter logic [`PULSE_CNT_W-1:0] INT_PERIOD_CYC = `PULSE_CNT_W'(`INT_PERIOD_CYC)
) (
  // clock and reset
  input  wire logic              CORE_CLK_I,
  input  wire logic              RST_B_I,
  // register port
  input  wire logic              REG_WR_I,
  input  wire logic              REG_RD_I,
  input  wire logic [`REG_AW-1:0] REG_ADDR_I,
  input  wire logic [`REG_DW-1:0] REG_WDATA_I,
  output logic      [`REG_DW-1:0] REG_RDATA_O,
  // output sources
  input  wire logic              SER_DATA_I,
  input  wire logic              DIV_CLK_I,
  input  wire logic              SEC_BCLK_OUT_I,
  input  wire logic              SEC_WCLK_OUT_I,
  input  wire logic              MOD_CLK_I,
  // interrupt events and modes
  input  wire logic              INT_A_EVENT_I,
  input  wire logic              INT_A_REPEAT_I,
  input  wire logic              INT_B_EVENT_I,
  input  wire logic              INT_B_REPEAT_I,
  input  wire logic              FLAG_READ_I,
  // mic data pin pad
  input  wire logic              MIC_PIN_I,
  output logic                   MIC_PIN_O,
  output logic                   MIC_PIN_OE_O,
  output logic                   MIC_PIN_IE_O,
  // mic pin input routes
  output logic                   MIC_IN_LEVEL_O,
  output logic                   GEN_INPUT_O,
  // serial out pin pad
  output logic                   SDOUT_PIN_O,
  output logic                   SDOUT_PIN_OE_O,
  output logic                   SDOUT_KEEPER_EN_O
);

  // control registers
  pinmux_pkg::mic_func_t mic_func_reg;   // mic pin function
  logic                  mic_gpo_reg;    // mic pin output level
  pinmux_pkg::out_func_t out_func_reg;   // out pin function
  logic                  out_gpo_reg;    // out pin output level
  logic                  keep_dis_reg;   // keeper disable

  // pad input synchroniser
  logic                  mic_sync1_reg;  // first stage, read only by second
  logic                  mic_sync2_reg;  // settled pad level

  // interrupt lines
  logic                  int_a;          // shaped line a
  logic                  int_b;          // shaped line b

  // next values for pad flops
  logic                  mic_out_next;
  logic                  mic_oe_next;
  logic                  mic_ie_next;
  logic                  out_out_next;
  logic                  out_oe_next;
  logic                  mic_buf_val;    // level seen through input buffer
  logic [`REG_DW-1:0]    rdata_next;

  // decode of the two register numbers
  logic                  sel_mic;
  logic                  sel_out;
  assign sel_mic = (REG_ADDR_I == `MIC_REG_ADDR);
  assign sel_out = (REG_ADDR_I == `OUT_REG_ADDR);

  // mic pin control register; bit one and top bits are not stored
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      mic_func_reg <= `MIC_FUNC_RST; // R1
      mic_gpo_reg  <= `GPO_RST;
    end else if (REG_WR_I && sel_mic) begin
      mic_func_reg <= REG_WDATA_I[`MIC_FUNC_MSB:`MIC_FUNC_LSB];
      mic_gpo_reg  <= REG_WDATA_I[`GPO_BIT]; // R4
    end
  end

  // out pin control register; top bits are not stored
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      out_func_reg <= `OUT_FUNC_RST; // R12
      out_gpo_reg  <= `GPO_RST;
      keep_dis_reg <= `KEEP_DIS_RST; // R11
    end else if (REG_WR_I && sel_out) begin
      out_func_reg <= REG_WDATA_I[`OUT_FUNC_MSB:`OUT_FUNC_LSB];
      out_gpo_reg  <= REG_WDATA_I[`GPO_BIT]; // R13
      keep_dis_reg <= REG_WDATA_I[`KEEP_BIT]; // R11
    end
  end

  // two-flop synchroniser on the pad input
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      mic_sync1_reg <= 1'b0;
      mic_sync2_reg <= 1'b0;
    end else begin
      mic_sync1_reg <= MIC_PIN_I;
      mic_sync2_reg <= mic_sync1_reg;
    end
  end

  // a powered-down buffer reads as zero
  assign mic_buf_val = mic_sync2_reg & MIC_PIN_IE_O; // R10

  // interrupt line shapers
  int_pulse_shaper #(
    .PULSE_CYC  (INT_PULSE_CYC),
    .PERIOD_CYC (INT_PERIOD_CYC)
  ) u_int_a (
    .clk_i       (CORE_CLK_I),
    .rst_b_i     (RST_B_I),
    .event_i     (INT_A_EVENT_I),
    .repeat_i    (INT_A_REPEAT_I),
    .flag_read_i (FLAG_READ_I),
    .pulse_o     (int_a)
  );

  int_pulse_shaper #(
    .PULSE_CYC  (INT_PULSE_CYC),
    .PERIOD_CYC (INT_PERIOD_CYC)
  ) u_int_b (
    .clk_i       (CORE_CLK_I),
    .rst_b_i     (RST_B_I),
    .event_i     (INT_B_EVENT_I),
    .repeat_i    (INT_B_REPEAT_I),
    .flag_read_i (FLAG_READ_I),
    .pulse_o     (int_b)
  );

  // mic pin source select and buffer enables
  always_comb begin
    mic_out_next = 1'b0;
    mic_oe_next  = 1'b1; // R18
    mic_ie_next  = 1'b1;
    case (mic_func_reg)
      `MIC_F_OFF: begin
        mic_oe_next = 1'b0; // R1
        mic_ie_next = 1'b0; // R1
      end
      `MIC_F_IN,
      `MIC_F_GPI: begin
        mic_oe_next = 1'b0; // R2 R3
      end
      `MIC_F_GPO:    mic_out_next = mic_gpo_reg;    // R4
      `MIC_F_DIVCLK: mic_out_next = DIV_CLK_I;      // R5
      `MIC_F_INTA:   mic_out_next = int_a;          // R6
      `MIC_F_INTB:   mic_out_next = int_b;          // R6
      `MIC_F_SBCLK:  mic_out_next = SEC_BCLK_OUT_I; // R7
      `MIC_F_SWCLK:  mic_out_next = SEC_WCLK_OUT_I; // R7
      `MIC_F_MODCLK: mic_out_next = MOD_CLK_I;      // R8
      default: begin
        // reserved codes park the pin as if disabled
        mic_oe_next = 1'b0; // R9
        mic_ie_next = 1'b0; // R9
      end
    endcase
  end

  // out pin source select
  always_comb begin
    out_out_next = 1'b0;
    out_oe_next  = 1'b1; // R18
    case (out_func_reg)
      `OUT_F_OFF:    out_oe_next  = 1'b0;           // R12
      `OUT_F_SDATA:  out_out_next = SER_DATA_I;     // R12
      `OUT_F_GPO:    out_out_next = out_gpo_reg;    // R13
      `OUT_F_DIVCLK: out_out_next = DIV_CLK_I;      // R14
      `OUT_F_INTA:   out_out_next = int_a;          // R14
      `OUT_F_INTB:   out_out_next = int_b;          // R14
      `OUT_F_SBCLK:  out_out_next = SEC_BCLK_OUT_I; // R15
      `OUT_F_SWCLK:  out_out_next = SEC_WCLK_OUT_I; // R15
      default:       out_oe_next  = 1'b0;
    endcase
  end

  // mic pad flops; registering adds one cycle of skew to routed clocks
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      MIC_PIN_O    <= 1'b0;
      MIC_PIN_OE_O <= 1'b0;
      MIC_PIN_IE_O <= 1'b0;
    end else begin
      MIC_PIN_O    <= mic_out_next;
      MIC_PIN_OE_O <= mic_oe_next;
      MIC_PIN_IE_O <= mic_ie_next;
    end
  end

  // out pad flops; released in reset, then drive serial data as reset code one selects
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      SDOUT_PIN_O       <= 1'b0;
      SDOUT_PIN_OE_O    <= 1'b0;
      SDOUT_KEEPER_EN_O <= 1'b0;
    end else begin
      SDOUT_PIN_O       <= out_out_next;
      SDOUT_PIN_OE_O    <= out_oe_next;
      SDOUT_KEEPER_EN_O <= !keep_dis_reg; // R11
    end
  end

  // input level routes, zero unless the mode selects them
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      MIC_IN_LEVEL_O <= 1'b0;
      GEN_INPUT_O    <= 1'b0;
    end else begin
      MIC_IN_LEVEL_O <= (mic_func_reg == `MIC_F_IN) & mic_sync2_reg; // R2
      GEN_INPUT_O    <= (mic_func_reg == `MIC_F_GPI) & mic_sync2_reg; // R3
    end
  end

  // read word assembly; reserved bits read zero
  always_comb begin
    rdata_next = `RD_ZERO;
    if (sel_mic) begin
      rdata_next[`MIC_FUNC_MSB:`MIC_FUNC_LSB] = mic_func_reg;
      rdata_next[`MIC_BUF_BIT]                = mic_buf_val; // R10
      rdata_next[`GPO_BIT]                    = mic_gpo_reg;
    end else if (sel_out) begin
      rdata_next[`KEEP_BIT]                   = keep_dis_reg;
      rdata_next[`OUT_FUNC_MSB:`OUT_FUNC_LSB] = out_func_reg;
      rdata_next[`GPO_BIT]                    = out_gpo_reg;
    end
  end

  // read data held until the next read strobe
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      REG_RDATA_O <= `RD_ZERO;
    end else if (REG_RD_I) begin
      REG_RDATA_O <= rdata_next; // R3 R10
    end
  end

  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);

  mic_off_a: assert property ( // R1
    (mic_func_reg == `MIC_F_OFF) |=> !MIC_PIN_OE_O && !MIC_PIN_IE_O
  ) else $error("disabled mic pin has a live buffer");

  mic_input_a: assert property ( // R2
    (mic_func_reg == `MIC_F_IN) ##1 (mic_func_reg == `MIC_F_IN)
    |-> !MIC_PIN_OE_O && MIC_PIN_IE_O && (MIC_IN_LEVEL_O == $past(mic_sync2_reg))
  ) else $error("mic input mode wrong");

  gpi_read_a: assert property ( // R3
    REG_RD_I && sel_mic && MIC_PIN_IE_O && (mic_func_reg == `MIC_F_GPI)
    |=> REG_RDATA_O[`MIC_BUF_BIT] == $past(mic_sync2_reg)
  ) else $error("general input readback wrong");

  mic_gpo_a: assert property ( // R4
    (mic_func_reg == `MIC_F_GPO) |=> MIC_PIN_OE_O && (MIC_PIN_O == $past(mic_gpo_reg))
  ) else $error("mic output level wrong");

  mic_divclk_a: assert property ( // R5
    (mic_func_reg == `MIC_F_DIVCLK) |=> MIC_PIN_OE_O && (MIC_PIN_O == $past(DIV_CLK_I))
  ) else $error("mic pin lacks divided clock");

  mic_intb_a: assert property ( // R6
    (mic_func_reg == `MIC_F_INTB) |=> MIC_PIN_O == $past(int_b)
  ) else $error("mic pin lacks line b");

  mic_sbclk_a: assert property ( // R7
    (mic_func_reg == `MIC_F_SBCLK) |=> MIC_PIN_O == $past(SEC_BCLK_OUT_I)
  ) else $error("mic pin lacks bit clock");

  mic_modclk_a: assert property ( // R8
    (mic_func_reg == `MIC_F_MODCLK) |=> MIC_PIN_O == $past(MOD_CLK_I)
  ) else $error("mic pin lacks modulator clock");

  keeper_ctl_a: assert property ( // R11
    REG_WR_I && sel_out ##1 1'b1 |=> SDOUT_KEEPER_EN_O == !$past(REG_WDATA_I[`KEEP_BIT], 2)
  ) else $error("keeper enable not following register");

  out_off_a: assert property ( // R12
    (out_func_reg == `OUT_F_OFF) |=> !SDOUT_PIN_OE_O
  ) else $error("disabled out pin driven");

  out_gpo_a: assert property ( // R13
    (out_func_reg == `OUT_F_GPO) |=> SDOUT_PIN_OE_O && (SDOUT_PIN_O == $past(out_gpo_reg))
  ) else $error("out pin level wrong");

  out_inta_a: assert property ( // R14
    (out_func_reg == `OUT_F_INTA) |=> SDOUT_PIN_O == $past(int_a)
  ) else $error("out pin lacks line a");

  out_swclk_a: assert property ( // R15
    (out_func_reg == `OUT_F_SWCLK) |=> SDOUT_PIN_O == $past(SEC_WCLK_OUT_I)
  ) else $error("out pin lacks word clock");

  mic_drive_a: assert property ( // R18
    MIC_PIN_OE_O |-> !($past(mic_func_reg) inside {`MIC_F_OFF, `MIC_F_IN, `MIC_F_GPI})
  ) else $error("mic driver on in non-output mode");

  gpo_toggle_c: cover property (
    (mic_func_reg == `MIC_F_GPO) && $rose(MIC_PIN_O)
  );
  int_routed_c: cover property (
    (out_func_reg == `OUT_F_INTA) && $rose(SDOUT_PIN_O)
  );
  gpi_read_c: cover property (
    REG_RD_I && sel_mic && mic_buf_val
  );

endmodule : multifunction_pin_select

/* verification/multifunction_pin_select_tb_top.sv */
`timescale 1ns/1ps
`include "pinmux_cfg.svh"
`define CHK(nm, e, g) check(nm, 8'(e), 8'(g))

module multifunction_pin_select_tb_top;
  // one table row: register write and the pad state it should give
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [2:0] sel;  // index of the expected source, 7 for none
    logic       oe;
    logic       ie;
  } row_s;
  // only legal codes, reserved bits written as zero
  localparam row_s ROWS [17] = '{
    '{8'h34, 8'h00, 3'h7, 1'b0, 1'b0}, '{8'h34, 8'h01, 3'h7, 1'b0, 1'b0},
    '{8'h34, 8'h04, 3'h7, 1'b0, 1'b1}, '{8'h34, 8'h08, 3'h7, 1'b0, 1'b1},
    '{8'h34, 8'h0C, 3'h7, 1'b1, 1'b1}, '{8'h34, 8'h0D, 3'h7, 1'b1, 1'b1},
    '{8'h34, 8'h10, 3'h1, 1'b1, 1'b1}, '{8'h34, 8'h20, 3'h2, 1'b1, 1'b1},
    '{8'h34, 8'h24, 3'h3, 1'b1, 1'b1}, '{8'h34, 8'h28, 3'h4, 1'b1, 1'b1},
    '{8'h35, 8'h00, 3'h7, 1'b0, 1'b0}, '{8'h35, 8'h12, 3'h0, 1'b1, 1'b0},
    '{8'h35, 8'h05, 3'h7, 1'b1, 1'b0}, '{8'h35, 8'h14, 3'h7, 1'b1, 1'b0},
    '{8'h35, 8'h16, 3'h1, 1'b1, 1'b0}, '{8'h35, 8'h1C, 3'h2, 1'b1, 1'b0},
    '{8'h35, 8'h1E, 3'h3, 1'b1, 1'b0}};
  // interrupt routing codes: mic a, mic b, out a, out b
  localparam logic [7:0] INT_DAT [4] = '{8'h14, 8'h18, 8'h18, 8'h1A};

  // stimulus, all driven at the falling edge
  logic       clk = 1'b0, rst_b = 1'b0, wr = 1'b0, rd = 1'b0;
  logic [7:0] addr = 8'h00, wdata = 8'h00;
  logic [4:0] src = 5'h00;  // {mod, swclk, sbclk, div, ser}
  logic       int_a = 1'b0, int_b = 1'b0, rep_a = 1'b0, rep_b = 1'b0;
  logic       flag_rd = 1'b0, ext = 1'b1, on_out = 1'b0;
  // observed outputs
  logic [7:0] rdata;
  logic       mic_wire, mic_o, mic_oe, mic_ie, mic_lvl, gen_in, sd_o, sd_oe, keep_en, sd_wire;
  wire        pad = on_out ? sd_o : mic_o;  // pad under watch in pulse tests
  int         mismatches = 0, checks_done = 0, cyc = 0;

  // short pulse counts keep the interrupt tests brief
  multifunction_pin_select #(.INT_PULSE_CYC(18'h0_0004), .INT_PERIOD_CYC(18'h0_0008))
    u_multifunction_pin_select (
    .CORE_CLK_I(clk), .RST_B_I(rst_b), .REG_WR_I(wr), .REG_RD_I(rd),
    .REG_ADDR_I(addr), .REG_WDATA_I(wdata), .REG_RDATA_O(rdata),
    .SER_DATA_I(src[0]), .DIV_CLK_I(src[1]), .SEC_BCLK_OUT_I(src[2]),
    .SEC_WCLK_OUT_I(src[3]), .MOD_CLK_I(src[4]),
    .INT_A_EVENT_I(int_a), .INT_A_REPEAT_I(rep_a), .INT_B_EVENT_I(int_b),
    .INT_B_REPEAT_I(rep_b), .FLAG_READ_I(flag_rd),
    .MIC_PIN_I(mic_wire), .MIC_PIN_O(mic_o), .MIC_PIN_OE_O(mic_oe), .MIC_PIN_IE_O(mic_ie),
    .MIC_IN_LEVEL_O(mic_lvl), .GEN_INPUT_O(gen_in),
    .SDOUT_PIN_O(sd_o), .SDOUT_PIN_OE_O(sd_oe), .SDOUT_KEEPER_EN_O(keep_en));

  pin_board_model u_pin_board_model (
    .clk_i(clk), .ext_level_i(ext), .mic_o_i(mic_o), .mic_oe_i(mic_oe),
    .sd_o_i(sd_o), .sd_oe_i(sd_oe), .keeper_en_i(keep_en),
    .mic_wire_o(mic_wire), .sd_wire_o(sd_wire));

  // 40 MHz clock
  always #12.5 clk = ~clk;

  // hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      mismatches++;
      stop_test();
    end
  end

  task automatic check(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : check

  task automatic stop_test();
    if (mismatches == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : stop_test

  // one-cycle write strobe
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    wr = 1'b1;
    addr = a;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
  endtask : wr_reg

  // read strobe, data sampled one cycle after it is taken
  task automatic rd_reg(input logic [7:0] a);
    @(negedge clk);
    rd = 1'b1;
    addr = a;
    @(negedge clk);
    rd = 1'b0;
    @(negedge clk);
  endtask : rd_reg

  // counts falling-edge samples of the pad at one level, bounded
  task automatic measure(input logic lvl, input int max, output int n);
    n = 0;
    while (pad === lvl && n < max) begin
      n++;
      @(negedge clk);
    end
  endtask : measure

  // one-cycle interrupt event on line a or b
  task automatic fire(input logic b, input logic rep);
    @(negedge clk);
    if (b) begin
      int_b = 1'b1;
      rep_b = rep;
    end else begin
      int_a = 1'b1;
      rep_a = rep;
    end
    @(negedge clk);
    int_a = 1'b0;
    int_b = 1'b0;
  endtask : fire

  // reset held six cycles, then the reset state is checked
  task automatic do_reset();
    rst_b = 1'b0;
    repeat (6) @(negedge clk);
    rst_b = 1'b1;
    repeat (2) @(negedge clk);
    `CHK("out oe after reset", 1, sd_oe);
    `CHK("keeper after reset", 0, keep_en);
    `CHK("mic oe after reset", 0, mic_oe);
    `CHK("mic ie after reset", 0, mic_ie);
    rd_reg(`MIC_REG_ADDR);
    `CHK("mic reg reset", 8'h00, rdata);
    rd_reg(`OUT_REG_ADDR);
    `CHK("out reg reset", 8'h12, rdata);
  endtask : do_reset

  initial begin
    row_s r;
    logic eo, lvl;
    int   n;
    do_reset();
    // table: each row twice, selected source high then all others high
    for (int i = 0; i < 17; i++) begin
      for (int p = 0; p < 2; p++) begin
        r = ROWS[i];
        src = (r.sel < 3'h5) ? ((5'h01 << r.sel) ^ {5{p[0]}}) : 5'h00;
        eo = (r.sel < 3'h5) ? ~p[0] : r.wdata[0];
        ext = ~p[0];
        wr_reg(r.addr, r.wdata);
        repeat (4) @(negedge clk);
        rd_reg(r.addr);
        if (r.addr == `MIC_REG_ADDR) begin
          lvl = r.oe ? eo : ext;
          `CHK("mic readback", {2'b00, r.wdata[5:2], lvl & r.ie, r.wdata[0]}, rdata);
          `CHK("mic oe", r.oe, mic_oe);
          `CHK("mic ie", r.ie, mic_ie);
          if (r.oe) `CHK("mic pad", eo, mic_o);
          `CHK("mic level", (r.wdata[5:2] == `MIC_F_IN) & ext, mic_lvl);
          `CHK("gen input", (r.wdata[5:2] == `MIC_F_GPI) & ext, gen_in);
        end else begin
          `CHK("out readback", {3'b000, r.wdata[4:0]}, rdata);
          `CHK("out oe", r.oe, sd_oe);
          `CHK("keeper", !r.wdata[4], keep_en);
          if (r.oe) `CHK("out pad", eo, sd_o);
          // a released wire with the keeper on must not wander
          if (!r.oe) begin
            lvl = sd_wire;
            @(negedge clk);
            `CHK("out wire kept", lvl, sd_wire);
          end
        end
      end
    end
    // unmapped read returns zero
    rd_reg(8'h36);
    `CHK("unmapped read", 8'h00, rdata);
    // single pulses of both lines on both pins
    for (int i = 0; i < 4; i++) begin
      on_out = i[1];
      wr_reg(i < 2 ? `MIC_REG_ADDR : `OUT_REG_ADDR, INT_DAT[i]);
      repeat (4) @(negedge clk);
      fire(i[0], 1'b0);
      measure(1'b0, 4, n);
      `CHK("pulse start", 1, pad);
      measure(1'b1, 8, n);
      `CHK("pulse high", 4, n);
      measure(1'b0, 12, n);
      `CHK("pulse low after", 12, n);
    end
    // pulse train ended by a flag read during a high phase
    on_out = 1'b0;
    wr_reg(`MIC_REG_ADDR, 8'h14);
    repeat (4) @(negedge clk);
    fire(1'b0, 1'b1);
    measure(1'b0, 4, n);
    measure(1'b1, 8, n);
    `CHK("train high", 4, n);
    measure(1'b0, 8, n);
    `CHK("train low", 4, n);
    fork
      begin
        @(negedge clk);
        flag_rd = 1'b1;
        @(negedge clk);
        flag_rd = 1'b0;
      end
      measure(1'b1, 8, n);
    join
    `CHK("last pulse high", 4, n);
    measure(1'b0, 12, n);
    `CHK("train stopped", 12, n);
    // second reset in mid-run
    do_reset();
    stop_test();
  end
endmodule : multifunction_pin_select_tb_top

/* verification/pin_board_model.sv */
`timescale 1ns/1ps

// board side of both pads: microphone data source, keeper and floating wire
module pin_board_model (
  // clock
  input  wire logic clk_i,
  // level the microphone puts on the mic pin
  input  wire logic ext_level_i,
  // mic pin pad from the device
  input  wire logic mic_o_i,
  input  wire logic mic_oe_i,
  // serial out pad from the device
  input  wire logic sd_o_i,
  input  wire logic sd_oe_i,
  input  wire logic keeper_en_i,
  // resolved wire levels
  output logic      mic_wire_o,
  output logic      sd_wire_o
);
  logic sd_last_reg = 1'b0;  // last level seen on the out wire

  // device wins while it drives, otherwise the microphone drives the wire
  assign mic_wire_o = mic_oe_i ? mic_o_i : ext_level_i;

  // a released wire holds only with the keeper on, else it wanders each cycle
  assign sd_wire_o = sd_oe_i ? sd_o_i : (keeper_en_i ? sd_last_reg : ~sd_last_reg);

  // remember the wire so the keeper has something to hold
  always @(posedge clk_i) begin
    sd_last_reg <= sd_wire_o;
  end
endmodule : pin_board_model
